// [rtl/ldo_ctrl_map.svh]
/*
  Offsets, field positions, reset values and timing counts for the
  linear-regulator mode, bias and power-good controller.
  Assumes a 100 MHz aclk and an 8-bit byte address on the register bus.
*/
// Notes on behaviour
// - shared bias is on when any regulator is enabled or force bit set
// - global bias follows the shared regulator bias
// - ramp waits bias turn-on plus regulator turn-on if bias was off
// - two-bit mode per regulator; code 0b10 forces low power alone
// - group mode regulators are low power exactly while global signal high
// - global low-power signal is a control bit or the first general pin
// - sequencer-sourced regulator enabled by sequencer only; mode picks power
// - per-regulator select bit chooses one of two soft-start slew rates
// - the same slew applies to voltage changes while enabled, both ways
// - ramp starts from the existing output voltage, no forced discharge
// - each regulator reports power good, low below regulation threshold
// - power-good filtered so glitches shorter than 25 us are ignored
// - power-good fall sets per-regulator flag, summarised as top-level bit
// - clamp is off whenever the regulator is in low-power mode
// - in normal mode clamp follows its enable bit, reset to enabled
`ifndef LDO_CTRL_MAP_SVH
`define LDO_CTRL_MAP_SVH

`define NUM_REG          9
`define CTRL_OFS         8'h00
`define IRQ_STATUS_OFS   8'h04
`define IRQ_CLEAR_OFS    8'h08
`define IRQ_ENABLE_OFS   8'h0C
`define STATE_OFS        8'h10
`define CFG_BASE_OFS     8'h20
`define CTRL_BIAS_FORCE  0
`define CTRL_GLOBAL_LP   1
`define STATE_TOP_IRQ    16
`define STATE_BIAS_READY 17
`define CFG_RESET        7'h10
`define LP_CODE          2'h2

`define CLK_PERIOD_NS    10
`define BIAS_ON_TIME_NS  2000
`define REG_ON_TIME_NS   1000
`define POK_FILTER_NS    25000
`define BIAS_ON_CYC ((`BIAS_ON_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_ON_CYC  ((`REG_ON_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POK_CYC     ((`POK_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/ldo_ctrl_pkg.sv]
/*
  Types shared by the regulator controller and its bench.
  Assumes nine regulators, each with one seven-bit configuration word.
*/
package ldo_ctrl_pkg;

  typedef enum logic [1:0] {
    MODE_OFF      = 2'h0,
    MODE_GROUP_LP = 2'h1,
    MODE_FORCE_LP = 2'h2,
    MODE_NORMAL   = 2'h3
  } pwr_mode_t;

  // one configuration word per regulator, bits [6:0]
  typedef struct packed {
    logic [1:0] compensation_select;
    logic       overvoltage_sink_enable;
    logic       soft_start_rate_select;
    logic       regulator_sequencer_source;
    pwr_mode_t  regulator_power_mode_field;
  } reg_cfg_t;

  // drive bundle for one regulator's analog section
  typedef struct packed {
    logic       enable;
    logic       ramp_go;
    logic       low_power;
    logic       fast_slew;
    logic       clamp_en;
    logic [1:0] comp;
  } reg_drive_t;

  typedef enum logic [2:0] {
    BIAS_OFF   = 3'h1,
    BIAS_WARM  = 3'h2,
    BIAS_READY = 3'h4
  } bias_state_t;

endpackage

// [rtl/ldo_mode_bias_pok_control.sv]
/*
  Digital control for nine linear regulators: bias enable, ramp latency,
  power modes, slew select, clamp gating, filtered power good with
  interrupt, and an AXI4-Lite register slave.
  Assumes one 100 MHz clock; sequencer enables come from logic on aclk,
  power-good and the first general pin are asynchronous.
*/
`timescale 1ns/100ps
`include "ldo_ctrl_map.svh"

module ldo_mode_bias_pok_control (
  input  logic                   aclk,
  input  logic                   aresetn,
  input  logic [7:0]             awaddr,
  input  logic                   awvalid,
  output logic                   awready,
  input  logic [31:0]            wdata,
  input  logic [3:0]             wstrb,
  input  logic                   wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  logic                   bready,
  input  logic [7:0]             araddr,
  input  logic                   arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  logic                   rready,
  input  logic [8:0]             flexible_power_sequencer,
  input  logic                   first_general_pin,
  input  logic [8:0]             regulator_power_good,
  output ldo_ctrl_pkg::reg_drive_t [8:0] drive,
  output logic                   regulator_bias_en,
  output logic                   global_bias_en,
  output logic                   regulator_top_level_irq
);
  import ldo_ctrl_pkg::*;

  localparam int N = `NUM_REG;
  localparam logic [11:0] BIAS_CYC = 12'(`BIAS_ON_CYC);
  localparam logic [11:0] ON_CYC   = 12'(`REG_ON_CYC);
  localparam logic [11:0] POK_CYC  = 12'(`POK_CYC);

  // regulator index of a config word, or N when not a config offset
  function automatic logic [3:0] cfg_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `CFG_BASE_OFS;
    if (a >= `CFG_BASE_OFS && a[1:0] == 2'h0 && d[7:2] < 6'(N)) begin
      return d[5:2];
    end
    return 4'(N);
  endfunction

  // byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // software-visible state
  logic [1:0]  ctrl_reg;
  logic [8:0]  irq_status_reg;
  logic [8:0]  irq_enable_reg;
  reg_cfg_t    cfg_reg [N];

  // bus capture
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic        rd_ok;

  // synchronisers and filter
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic [8:0]  pok_meta_reg;
  logic [8:0]  pok_sync_reg;
  logic [8:0]  pok_filt_reg;
  logic [11:0] pok_cnt_reg [N];
  logic [8:0]  pok_fall;

  // regulator control
  logic        global_lp;
  logic [8:0]  reg_en;
  logic [8:0]  reg_lp;
  logic        bias_on;
  bias_state_t bias_state_reg;
  bias_state_t bias_state_next;
  logic [11:0] bias_cnt_reg;
  logic [11:0] on_cnt_reg [N];

  assign do_write = aw_held_reg && w_held_reg && !bvalid;
  assign wmask    = strb_mask(w_strb_reg);

  // write address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (awvalid && awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // ready only while the capture slot is empty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !(awvalid && awready) && !aw_held_reg;
      wready  <= !(wvalid && wready) && !w_held_reg;
    end
  end

  // write response; unmapped offsets answer slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= 2'h0;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (aw_addr_reg == `CTRL_OFS || aw_addr_reg == `IRQ_STATUS_OFS
                 || aw_addr_reg == `IRQ_CLEAR_OFS
                 || aw_addr_reg == `IRQ_ENABLE_OFS
                 || aw_addr_reg == `STATE_OFS
                 || cfg_index(aw_addr_reg) != 4'(N)) ? 2'h0 : 2'h2;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // control bits: bias force and global low power
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 2'h0;
    end else if (do_write && aw_addr_reg == `CTRL_OFS) begin
      ctrl_reg <= (ctrl_reg & ~wmask[1:0]) | (w_data_reg[1:0] & wmask[1:0]);
    end
  end

  // interrupt enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg <= 9'h000;
    end else if (do_write && aw_addr_reg == `IRQ_ENABLE_OFS) begin
      irq_enable_reg <= (irq_enable_reg & ~wmask[8:0])
                        | (w_data_reg[8:0] & wmask[8:0]);
    end
  end

  // sticky flags; a fall in the clearing cycle still lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 9'h000;
    end else if (do_write && aw_addr_reg == `IRQ_CLEAR_OFS) begin
      irq_status_reg <= (irq_status_reg & ~(w_data_reg[8:0] & wmask[8:0]))
                        | pok_fall;
    end else begin
      irq_status_reg <= irq_status_reg | pok_fall;
    end
  end

  // level interrupt from the unmasked flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regulator_top_level_irq <= 1'b0;
    end else begin
      regulator_top_level_irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (araddr == `CTRL_OFS) begin
      rd_word[1:0] = ctrl_reg;
    end else if (araddr == `IRQ_STATUS_OFS) begin
      rd_word[8:0] = irq_status_reg;
    end else if (araddr == `IRQ_CLEAR_OFS) begin
      rd_word = 32'h0000_0000; // write-only, reads zero
    end else if (araddr == `IRQ_ENABLE_OFS) begin
      rd_word[8:0] = irq_enable_reg;
    end else if (araddr == `STATE_OFS) begin
      rd_word[8:0]                = pok_filt_reg;
      rd_word[`STATE_TOP_IRQ]     = regulator_top_level_irq;
      rd_word[`STATE_BIAS_READY]  = (bias_state_reg == BIAS_READY);
    end else if (cfg_index(araddr) != 4'(N)) begin
      rd_word[6:0] = cfg_reg[cfg_index(araddr)];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'h0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid) begin
      rvalid  <= !rready;
      arready <= rready;
    end else begin
      arready <= 1'b1;
    end
  end

  // general pin crosses in through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pok_meta_reg <= 9'h000;
      pok_sync_reg <= 9'h000;
    end else begin
      pin_meta_reg <= first_general_pin;
      pin_sync_reg <= pin_meta_reg;
      pok_meta_reg <= regulator_power_good;
      pok_sync_reg <= pok_meta_reg;
    end
  end

  assign global_lp = ctrl_reg[`CTRL_GLOBAL_LP] | pin_sync_reg;
  assign bias_on   = |reg_en | ctrl_reg[`CTRL_BIAS_FORCE];

  // shared bias warm-up tracking
  always_comb begin
    bias_state_next = bias_state_reg;
    unique case (bias_state_reg)
      BIAS_OFF: begin
        if (bias_on) begin
          bias_state_next = BIAS_WARM;
        end
      end
      BIAS_WARM: begin
        if (!bias_on) begin
          bias_state_next = BIAS_OFF;
        end else if (bias_cnt_reg >= BIAS_CYC - 12'h001) begin
          bias_state_next = BIAS_READY;
        end
      end
      BIAS_READY: begin
        if (!bias_on) begin
          bias_state_next = BIAS_OFF;
        end
      end
      default: bias_state_next = BIAS_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_state_reg <= BIAS_OFF;
      bias_cnt_reg   <= 12'h000;
    end else begin
      bias_state_reg <= bias_state_next;
      bias_cnt_reg   <= (bias_state_reg == BIAS_WARM)
                        ? bias_cnt_reg + 12'h001 : 12'h000;
    end
  end

  // bias enables: global bias rides on the shared bias
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regulator_bias_en <= 1'b0;
      global_bias_en    <= 1'b0;
    end else begin
      regulator_bias_en <= bias_on;
      global_bias_en    <= bias_on;
    end
  end

  // per-regulator config, filter, latency and drive
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_reg
      // compensation is stored as written; changing it live is host's risk
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_reg[i] <= reg_cfg_t'(`CFG_RESET);
        end else if (do_write && cfg_index(aw_addr_reg) == 4'(i)) begin
          cfg_reg[i] <= reg_cfg_t'((cfg_reg[i] & ~wmask[6:0])
                                   | (w_data_reg[6:0] & wmask[6:0]));
        end
      end

      // sequencer overrides the software enable
      assign reg_en[i] = cfg_reg[i].regulator_sequencer_source
        ? flexible_power_sequencer[i]
        : (cfg_reg[i].regulator_power_mode_field != MODE_OFF);
      assign reg_lp[i] =
        (cfg_reg[i].regulator_power_mode_field == MODE_FORCE_LP)
        || (cfg_reg[i].regulator_power_mode_field == MODE_GROUP_LP
            && global_lp);

      // change must hold the full window before it is accepted
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pok_cnt_reg[i]  <= 12'h000;
          pok_filt_reg[i] <= 1'b0;
        end else if (pok_sync_reg[i] == pok_filt_reg[i]) begin
          pok_cnt_reg[i]  <= 12'h000;
        end else if (pok_cnt_reg[i] >= POK_CYC - 12'h001) begin
          pok_cnt_reg[i]  <= 12'h000;
          pok_filt_reg[i] <= pok_sync_reg[i];
        end else begin
          pok_cnt_reg[i]  <= pok_cnt_reg[i] + 12'h001;
        end
      end

      assign pok_fall[i] = pok_filt_reg[i] && !pok_sync_reg[i]
                           && pok_cnt_reg[i] >= POK_CYC - 12'h001;

      // turn-on delay runs only once the bias is ready
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          on_cnt_reg[i] <= 12'h000;
        end else if (!reg_en[i]) begin
          on_cnt_reg[i] <= 12'h000;
        end else if (bias_state_reg == BIAS_READY && on_cnt_reg[i] < ON_CYC) begin
          on_cnt_reg[i] <= on_cnt_reg[i] + 12'h001;
        end
      end

      // ramp_go only releases the ramp; no discharge ever precedes it
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          drive[i] <= '0;
        end else begin
          drive[i].enable    <= reg_en[i];
          drive[i].ramp_go   <= reg_en[i] && on_cnt_reg[i] == ON_CYC;
          drive[i].low_power <= reg_lp[i];
          drive[i].fast_slew <= cfg_reg[i].soft_start_rate_select;
          drive[i].clamp_en  <= !reg_lp[i]
            && cfg_reg[i].overvoltage_sink_enable;
          drive[i].comp      <= cfg_reg[i].compensation_select;
        end
      end
    end
  endgenerate

endmodule

// [verif/ldo_ctrl_monitor.sv]
/* checker of the regulator controller ports, bound to its top.
   assumes one aclk domain and a synchronous active-low reset. */
`timescale 1ns/100ps
`include "ldo_ctrl_map.svh"
module ldo_ctrl_monitor (
  input logic                           aclk,
  input logic                           aresetn,
  input logic                           bvalid,
  input ldo_ctrl_pkg::reg_drive_t [8:0] drive,
  input logic                           regulator_bias_en,
  input logic                           global_bias_en,
  input logic                           regulator_top_level_irq
);
  import ldo_ctrl_pkg::*;
  localparam int ramp_lo = `BIAS_ON_CYC + `REG_ON_CYC - 4;
  localparam int ramp_hi = `BIAS_ON_CYC + `REG_ON_CYC + 12;
  logic [8:0] en_vec;
  logic [8:0] lp_vec;
  logic [8:0] cl_vec;
  logic [9:0] en_cnt;
  logic [9:0] bias_cnt;
  // field views of the drive bundle
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      en_vec[i] = drive[i].enable;
      lp_vec[i] = drive[i].low_power;
      cl_vec[i] = drive[i].clamp_en;
    end
  end
  // run length of regulator 0 enable, saturating so it never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn || !drive[0].enable) begin
      en_cnt <= 10'h000;
    end else if (en_cnt != 10'h3FF) begin
      en_cnt <= en_cnt + 10'h001;
    end
  end
  // run length of the shared bias
  always_ff @(posedge aclk) begin
    if (!aresetn || !regulator_bias_en) begin
      bias_cnt <= 10'h000;
    end else if (bias_cnt != 10'h3FF) begin
      bias_cnt <= bias_cnt + 10'h001;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bias_on_en_a: assert property ((|en_vec) [*2] |-> regulator_bias_en)
    else $error("bias low with a regulator enabled");
  bias_fall_a: assert property ($fell(regulator_bias_en) |->
    en_vec == 9'h000 || $past(en_vec) == 9'h000)
    else $error("bias dropped while enabled");
  bias_global_a: assert property (regulator_bias_en == global_bias_en)
    else $error("global bias differs from shared bias");
  ramp_early_a: assert property ($rose(drive[0].ramp_go) |->
    bias_cnt >= ramp_lo && en_cnt >= `REG_ON_CYC - 2)
    else $error("ramp started too early");
  ramp_late_a: assert property (en_cnt == 10'(ramp_hi) |->
    drive[0].ramp_go)
    else $error("ramp started too late");
  ramp_idle_a: assert property (!drive[0].enable [*2] |->
    !drive[0].ramp_go)
    else $error("ramp while disabled");
  clamp_lp_a: assert property ((lp_vec & cl_vec) == 9'h000)
    else $error("clamp on in low power");
  irq_fall_a: assert property ($fell(regulator_top_level_irq) |->
    $past(bvalid) || $past(bvalid, 2) || $past(bvalid, 3))
    else $error("interrupt dropped without a write");
endmodule

bind ldo_mode_bias_pok_control ldo_ctrl_monitor u_ldo_ctrl_monitor (
  .aclk(aclk),
  .aresetn(aresetn),
  .bvalid(bvalid),
  .drive(drive),
  .regulator_bias_en(regulator_bias_en),
  .global_bias_en(global_bias_en),
  .regulator_top_level_irq(regulator_top_level_irq)
);

// [verif/ldo_mode_bias_pok_control_tb.sv]
/* bench of the regulator controller: register bus, modes, sequencer,
   bias latency, filtered power good and its interrupt.
   assumes the design's map header and package. */
`timescale 1ns/100ps
`include "ldo_ctrl_map.svh"
module ldo_mode_bias_pok_control_tb;
  import ldo_ctrl_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic [7:0]       awaddr = 8'h00;
  logic [7:0]       araddr = 8'h00;
  logic [31:0]      wdata = 32'h0;
  logic             awvalid = 1'b0;
  logic             wvalid = 1'b0;
  logic             bready = 1'b0;
  logic             arvalid = 1'b0;
  logic             rready = 1'b0;
  logic [8:0]       seq_en = 9'h000;
  logic [8:0]       pg = 9'h1FF;
  logic             gpin = 1'b0;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [1:0]       bresp, rresp, rsp;
  logic [31:0]      rdata, rd;
  reg_drive_t [8:0] drive;
  logic             bias_en, gbias_en, irq;
  int               failures = 0;
  int               compares = 0;
  int               n;

  ldo_mode_bias_pok_control u_ldo_mode_bias_pok_control (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .flexible_power_sequencer(seq_en), .first_general_pin(gpin),
    .regulator_power_good(pg), .drive(drive),
    .regulator_bias_en(bias_en), .global_bias_en(gbias_en),
    .regulator_top_level_irq(irq)
  );

  // free-running 100 MHz clock
  always #5 aclk = ~aclk;

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask

  // a bound that runs out is a mismatch and ends the run at the verdict
  task automatic give_up(input string what);
    failures++;
    $display("ERROR %s expected answer got timeout", what);
    summarize();
  endtask

  // one write; a fresh edge first so bready never toggles twice a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 200) give_up("write handshake");
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 200) give_up("read handshake");
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // outputs are registered, so let a few edges land before looking
  task automatic cfg(input int i, input logic [6:0] v);
    wr(`CFG_BASE_OFS + 8'(4 * i), {25'h0, v});
    repeat (3) @(posedge aclk);
  endtask

  task automatic lat(input string what, input int i, input int lo);
    for (n = 0; n < 1000 && drive[i].ramp_go !== 1'b1; n++) begin
      @(posedge aclk);
    end
    if (n == 1000) give_up(what);
    check(what, 1'b1, n >= lo - 5 && n <= lo + 12);
  endtask

  task automatic t_reset();
    rd_reg(`CFG_BASE_OFS);
    check("cfg reset", 32'h10, rd);
    check("clamp reset", 1'b1, drive[0].clamp_en);
    rd_reg(`IRQ_ENABLE_OFS);
    check("irq enable reset", 32'h0, rd);
    rd_reg(8'h18);
    check("unmapped rresp", 2'h2, rsp);
    wr(8'h1C, 32'hFFFFFFFF);
    check("unmapped bresp", 2'h2, rsp);
    $display("t_reset done");
  endtask

  task automatic t_ramp();
    check("bias idle", 2'b00, {gbias_en, bias_en});
    wr(`CFG_BASE_OFS, 32'h13);
    lat("cold ramp", 0, `BIAS_ON_CYC + `REG_ON_CYC);
    check("bias on", 2'b11, {gbias_en, bias_en});
    wr(`CFG_BASE_OFS + 8'h0C, 32'h13);
    lat("warm ramp", 3, `REG_ON_CYC);
    wr(`CTRL_OFS, 32'h1);
    wr(`CFG_BASE_OFS, 32'h10);
    wr(`CFG_BASE_OFS + 8'h0C, 32'h10);
    repeat (4) @(posedge aclk);
    check("forced bias", 2'b11, {gbias_en, bias_en});
    wr(`CFG_BASE_OFS + 8'h10, 32'h13);
    lat("forced ramp", 4, `REG_ON_CYC);
    wr(`CFG_BASE_OFS + 8'h10, 32'h10);
    wr(`CTRL_OFS, 32'h0);
    repeat (4) @(posedge aclk);
    check("bias off", 2'b00, {gbias_en, bias_en});
    $display("t_ramp done");
  endtask

  task automatic t_modes();
    logic [1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      // compensation only moves while the regulator is off
      cfg(1, {m, 5'h10});
      cfg(1, {m, 1'b1, m[0], 1'b0, m});
      check("mode enable", m != 2'h0, drive[1].enable);
      check("mode lp", m == 2'h2, drive[1].low_power);
      check("mode clamp", m != 2'h2, drive[1].clamp_en);
      check("slew", m[0], drive[1].fast_slew);
      check("comp", m, drive[1].comp);
      cfg(1, {m, 5'h10});
    end
    cfg(1, 7'h10);
    cfg(1, 7'h11);
    for (int k = 0; k < 5; k++) begin
      wr(`CTRL_OFS, {30'h0, k[0], 1'b0});
      gpin <= k[1];
      repeat (6) @(posedge aclk);
      check("group lp", k % 4 != 0, drive[1].low_power);
      check("group clamp", k % 4 == 0, drive[1].clamp_en);
    end
    cfg(1, 7'h03);
    check("clamp bit off", 1'b0, drive[1].clamp_en);
    cfg(1, 7'h10);
    $display("t_modes done");
  endtask

  task automatic t_seq();
    cfg(2, 7'h17);
    check("seq off", 1'b0, drive[2].enable);
    seq_en[2] <= 1'b1;
    repeat (3) @(posedge aclk);
    check("seq on", 1'b1, drive[2].enable);
    cfg(2, 7'h16);
    check("seq lp", 1'b1, drive[2].low_power);
    cfg(2, 7'h14);
    check("seq mode off", 1'b1, drive[2].enable);
    seq_en[2] <= 1'b0;
    repeat (3) @(posedge aclk);
    check("seq drop", 1'b0, drive[2].enable);
    cfg(2, 7'h10);
    $display("t_seq done");
  endtask

  task automatic stat(input string what, input logic [8:0] s,
                      input logic i);
    rd_reg(`IRQ_STATUS_OFS);
    check(what, {23'h0, s}, rd);
    check(what, i, irq);
  endtask

  task automatic t_pok();
    rd = 32'h0;
    for (int k = 0; k < 1500 && rd[8:0] !== 9'h1FF; k++) rd_reg(`STATE_OFS);
    check("pok settled", 32'h1FF, rd & 32'h1FF);
    wr(`IRQ_ENABLE_OFS, 32'h20);
    pg[5] <= 1'b0;
    // just under the filter window, so a short filter would let it through
    repeat (2400) @(posedge aclk);
    pg[5] <= 1'b1;
    stat("glitch", 9'h000, 1'b0);
    pg[6] <= 1'b0;
    repeat (2600) @(posedge aclk);
    stat("masked", 9'h040, 1'b0);
    pg[5] <= 1'b0;
    repeat (2600) @(posedge aclk);
    stat("unmasked", 9'h060, 1'b1);
    rd_reg(`STATE_OFS);
    check("state", 32'h1019F, rd & 32'h301FF);
    pg <= 9'h1FF;
    repeat (2600) @(posedge aclk);
    stat("sticky", 9'h060, 1'b1);
    wr(`IRQ_CLEAR_OFS, 32'h20);
    stat("cleared", 9'h040, 1'b0);
    wr(`IRQ_ENABLE_OFS, 32'h40);
    stat("unmask", 9'h040, 1'b1);
    wr(`IRQ_CLEAR_OFS, 32'h40);
    stat("all clear", 9'h000, 1'b0);
    $display("t_pok done");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ramp();
    t_modes();
    t_seq();
    t_pok();
    summarize();
  end
endmodule
